// ==== hdl/alu_bit_map.svh ====
// Offsets, field positions, reset values and timing counts for the ALU block
`ifndef ALU_BIT_MAP_SVH
`define ALU_BIT_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses on APB)
`define OFS_CTRL        12'h000
`define OFS_OPERAND     12'h004
`define OFS_ACC         12'h008
`define OFS_FLAGS       12'h00C
`define OFS_STATUS      12'h010
`define OFS_CFG         12'h014

// ==========================================================================
// Field positions
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     4
`define CTRL_OP_W       3
`define OPND_LIT_LSB    0
`define OPND_ADDR_LSB   8
`define OPND_BIT_LSB    16
`define OPND_DEST_BIT   20
`define FLAG_C_BIT      0
`define FLAG_HC_BIT     1
`define FLAG_Z_BIT      2
`define STAT_BUSY_BIT   0
`define STAT_SKIP_BIT   1
`define STAT_PSCLR_BIT  2
`define CFG_PSA_BIT     0

// ==========================================================================
// Reset values and special file addresses
`define ACC_RST         8'h00
`define FLAGS_RST       3'h0
`define TIMER_ADDR      7'h01
`define IO_LO_ADDR      7'h05
`define IO_HI_ADDR      7'h09

// ==========================================================================
// Timing counts (instruction cycles)
`define CYC_SINGLE      2'h1
`define CYC_DOUBLE      2'h2

`endif

// ==== hdl/alu_bit_pkg.sv ====
// Types shared by the ALU datapath block
package alu_bit_pkg;

  // ========================================================================
  // Supported operations
  typedef enum logic [2:0] {
    OP_ADD_LIT = 3'h0,
    OP_ADD_FILE = 3'h1,
    OP_AND_LIT = 3'h2,
    OP_AND_FILE = 3'h3,
    OP_BIT_CLR = 3'h4,
    OP_BIT_SET = 3'h5,
    OP_SKIP_ONE = 3'h6,
    OP_NOP = 3'h7
  } op_t;

  // Decoded instruction fields
  typedef struct packed {
    op_t        op;
    logic [7:0] lit;
    logic [6:0] addr;
    logic [2:0] bsel;
    logic       dest;
  } instr_t;

  // Flags: zero, half carry, carry
  typedef struct packed {
    logic z;
    logic hc;
    logic c;
  } flags_t;

  // File register port
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

endpackage

// ==== hdl/alu_bit_adder.sv ====
// Eight-bit adder with nibble carry, and bitwise AND
`timescale 1ns/1ps
module alu_bit_adder (
  // Operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  // Results
  output logic      [7:0] sum,
  output logic      [7:0] conj,
  output logic            c_out,
  output logic            hc_out
);
  logic [4:0] lo;
  logic [4:0] hi;

  // Split at bit 3 so the half carry falls out directly
  always_comb begin
    lo     = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    hi     = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    sum    = {hi[3:0], lo[3:0]};
    hc_out = lo[4];
    c_out  = hi[4];
    conj   = a & b;
  end
endmodule

// ==== hdl/alu_bit_file.sv ====
// File register store: 128 bytes, I/O addresses read from pins
`timescale 1ns/1ps
`include "alu_bit_map.svh"
module alu_bit_file
  import alu_bit_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // Write and read
  input  wire alu_bit_pkg::file_wr_t wr,
  input  wire logic [6:0]        raddr,
  output logic      [7:0]        rdata,
  // Port pins
  input  wire logic [31:0]       pins_in
);
  import alu_bit_pkg::*;

  logic [7:0] mem [128];
  logic       is_io;

  // Flip-flop storage, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) mem[i] <= 8'h00;
    end else if (ce && wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Reads of port addresses see the pins, not the latch
  always_comb begin
    is_io = (raddr >= `IO_LO_ADDR) && (raddr < `IO_HI_ADDR);
    if (is_io) begin
      rdata = pins_in[8*(raddr - `IO_LO_ADDR) +: 8];
    end else begin
      rdata = mem[raddr];
    end
  end
endmodule

// ==== hdl/alu_bit_core.sv ====
// Top: APB-driven arithmetic, logic and bit operation datapath
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "alu_bit_map.svh"
// Behaviour
// - A read-modify-write of a port register uses the pin levels, not the latch.
// - Writing the timer count register clears the prescaler when assigned to the timer.
// - An op that changes the program counter or takes its skip lasts two cycles, the second a no-op.
// - Add literal adds an 8-bit immediate to the accumulator, stores it there and sets C, HC, Z.
// - Bit clear forces the selected bit of the file register to zero, flags untouched.
// - Bit set forces the selected bit of the file register to one, flags untouched.
// - Add file adds accumulator and file register, sets C, HC, Z, stores by destination bit.
// - And file ANDs accumulator and file register, sets Z only, stores by destination bit.
// - And literal ANDs accumulator with an immediate into the accumulator, sets Z only.
// - Skip if bit one discards the next op when the bit is one, taking two cycles, no flags.
module alu_bit_core
  import alu_bit_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port pins and timer hooks
  input  wire logic [31:0] pins_in,
  output logic             prescaler_clr,
  output logic             skip_next
);
  import alu_bit_pkg::*;

  // ========================================================================
  // State
  // Idle, execute, and the inserted no-op of a taken skip
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} exec_state_t;

  exec_state_t state_r;
  instr_t      instr_r;
  logic [7:0]  acc_r;
  flags_t      flags_r;
  logic        psa_r;
  logic        skip_r;
  logic        psclr_r;
  file_wr_t    fwr;
  logic [7:0]  fdata;
  logic [7:0]  opnd_b;
  logic [7:0]  sum;
  logic [7:0]  conj;
  logic        c_out;
  logic        hc_out;
  logic [7:0]  res;
  logic        res_to_file;
  logic        skip_take;
  logic        wr_acc;
  logic        upd_arith;
  logic        upd_z;
  logic        acc_wr;
  logic        go;
  logic [31:0] rd_nxt;
  logic        err_nxt;
  logic [1:0]  cyc_need;
  logic        tmr_hit;

  // ========================================================================
  // Submodules
  // File store; port addresses answer with the pin levels
  alu_bit_file u_file (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr      (fwr),
    .raddr   (instr_r.addr),
    .rdata   (fdata),
    .pins_in (pins_in)
  );

  // One adder also gives the AND, so both paths share one operand mux
  alu_bit_adder u_add (
    .a      (acc_r),
    .b      (opnd_b),
    .sum    (sum),
    .conj   (conj),
    .c_out  (c_out),
    .hc_out (hc_out)
  );

  // ========================================================================
  // APB decode; access completes in the access phase, no wait states
  // Writes are taken only at the access edge; setup alone changes nothing
  assign acc_wr = psel && penable && pwrite && pready;
  assign go     = acc_wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_GO_BIT] && state_r == ST_IDLE;

  // Ready is a flop: low in setup, high in the access phase
  // ce low freezes it; frozen low at the setup edge it never rises, as the access phase then loads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
    end
  end

  // ========================================================================
  // Register reads
  // Read mux; any address outside the map answers with an error
  // and reads as zero
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    unique case (paddr)
      `OFS_CTRL:    rd_nxt = {28'h0000000, 1'b0, instr_r.op};
      `OFS_OPERAND: rd_nxt = {11'h000, instr_r.dest, 1'b0, instr_r.bsel,
                              1'b0, instr_r.addr, instr_r.lit};
      `OFS_ACC:     rd_nxt = {24'h000000, acc_r};
      `OFS_FLAGS:   rd_nxt = {29'h00000000, flags_r};
      `OFS_STATUS:  rd_nxt = {29'h00000000, psclr_r, skip_r, state_r != ST_IDLE};
      `OFS_CFG:     rd_nxt = {31'h00000000, psa_r};
      default:      err_nxt = 1'b1;
    endcase
  end

  // Read data registered on the setup cycle; zero outside the access phase
  // keeps stale register contents off the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Error flag rises with pready for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= psel && !penable && err_nxt;
    end
  end

  // ========================================================================
  // Register writes
  // Operation and operand fields; held while busy so a running op never
  // sees its operands change under it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r <= '{op: OP_NOP, lit: 8'h00, addr: 7'h00, bsel: 3'h0, dest: 1'b0};
    end else if (ce && acc_wr && state_r == ST_IDLE) begin
      if (paddr == `OFS_CTRL) begin
        instr_r.op <= op_t'(pwdata[`CTRL_OP_LSB +: `CTRL_OP_W]);
      end
      if (paddr == `OFS_OPERAND) begin
        instr_r.lit  <= pwdata[`OPND_LIT_LSB +: 8];
        instr_r.addr <= pwdata[`OPND_ADDR_LSB +: 7];
        instr_r.bsel <= pwdata[`OPND_BIT_LSB +: 3];
        instr_r.dest <= pwdata[`OPND_DEST_BIT];
      end
    end
  end

  // Prescaler assignment; a change while busy would race the timer check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psa_r <= 1'b0;
    end else if (ce && acc_wr && state_r == ST_IDLE && paddr == `OFS_CFG) begin
      psa_r <= pwdata[`CFG_PSA_BIT];
    end
  end

  // ========================================================================
  // Execute datapath
  always_comb begin
    opnd_b      = instr_r.lit;
    res         = acc_r;
    res_to_file = 1'b0;
    wr_acc      = 1'b0;
    upd_arith   = 1'b0;
    upd_z       = 1'b0;
    skip_take   = 1'b0;
    unique case (instr_r.op)
      OP_ADD_LIT: begin
        res       = sum;
        wr_acc    = 1'b1;
        upd_arith = 1'b1;
      end
      OP_ADD_FILE: begin
        opnd_b      = fdata;
        res         = sum;
        upd_arith   = 1'b1;
        res_to_file = instr_r.dest;
        wr_acc      = !instr_r.dest;
      end
      OP_AND_LIT: begin
        res    = conj;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_AND_FILE: begin
        opnd_b      = fdata;
        res         = conj;
        upd_z       = 1'b1;
        res_to_file = instr_r.dest;
        wr_acc      = !instr_r.dest;
      end
      // Port addresses read the pins here, so a bit op rewrites pin levels
      OP_BIT_CLR: begin
        res         = fdata & ~(8'h01 << instr_r.bsel);
        res_to_file = 1'b1;
      end
      OP_BIT_SET: begin
        res         = fdata | (8'h01 << instr_r.bsel);
        res_to_file = 1'b1;
      end
      OP_SKIP_ONE: skip_take = fdata[instr_r.bsel];
      OP_NOP: ;
    endcase
    fwr.we   = (state_r == ST_EXEC) && res_to_file;
    fwr.addr = instr_r.addr;
    fwr.data = res;
    // Timer count written while the prescaler belongs to the timer
    tmr_hit  = fwr.we && (fwr.addr == `TIMER_ADDR) && psa_r;
    // A taken skip costs a second, empty cycle
    cyc_need = skip_take ? `CYC_DOUBLE : `CYC_SINGLE;
  end

  // Sequencer: one cycle per op, a second no-op cycle when the skip is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      unique case (state_r)
        // A go while busy is dropped; software polls busy first
        ST_IDLE: if (go) state_r <= ST_EXEC;
        // The no-op cycle stands in for the discarded next instruction
        ST_EXEC: state_r <= (cyc_need == `CYC_DOUBLE) ? ST_NOP : ST_IDLE;
        ST_NOP:  state_r <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Results
  // Accumulator lands at the end of the execute cycle, ready for the next op
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `ACC_RST;
    end else if (ce && state_r == ST_EXEC && wr_acc) begin
      acc_r <= res;
    end
  end

  // Flags update in the same cycle; bit ops and the skip leave them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `FLAGS_RST;
    end else if (ce && state_r == ST_EXEC) begin
      if (upd_arith) begin
        flags_r.c  <= c_out;
        flags_r.hc <= hc_out;
      end
      if (upd_arith || upd_z) begin
        flags_r.z <= (res == 8'h00);
      end
    end
  end

  // ========================================================================
  // Hooks and status
  // Skip pulse for the fetch side; one cycle, in the no-op cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_next <= 1'b0;
    end else if (ce) begin
      skip_next <= (state_r == ST_EXEC) && skip_take;
    end
  end

  // Prescaler clear is a one-cycle pulse; a level would hold the
  // prescaler in reset for as long as the op stayed visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_clr <= 1'b0;
    end else if (ce) begin
      prescaler_clr <= (state_r == ST_EXEC) && tmr_hit;
    end
  end

  // Status markers of the last executed op, kept until the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_r  <= 1'b0;
      psclr_r <= 1'b0;
    end else if (ce && state_r == ST_EXEC) begin
      skip_r  <= skip_take;
      psclr_r <= tmr_hit;
    end
  end
endmodule

// ==== dv/alu_bit_chk_sva.sv ====
// Port assertions for the ALU datapath block
`timescale 1ns/1ps
`include "alu_bit_map.svh"
module alu_bit_chk (
  // Clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and hooks
  input wire logic [31:0] pins_in,
  input wire logic        prescaler_clr,
  input wire logic        skip_next
);
  // =========
  // Accepted go writes; hooks fire two edges later
  logic go_w;
  logic go_skip;
  assign go_w = psel && penable && pready && pwrite && ce && paddr == `OFS_CTRL && pwdata[0];
  assign go_skip = go_w && pwdata[6:4] == 3'h6;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT: assert property (psel && !penable && ce |=> pready)
    else $error("setup not answered next cycle");
  AST_READY_PULSE: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  AST_SKIP_CAUSE: assert property (skip_next |-> $past(go_skip, 2))
    else $error("skip pulse without skip op");
  AST_SKIP_PULSE: assert property (skip_next && ce |=> !skip_next)
    else $error("skip pulse longer than one cycle");
  AST_CLR_CAUSE: assert property (prescaler_clr |-> $past(go_w, 2))
    else $error("prescaler clear without op");
  AST_CLR_PULSE: assert property ($rose(prescaler_clr) |=> $fell(prescaler_clr))
    else $error("prescaler clear longer than one cycle");
endmodule

bind alu_bit_core alu_bit_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .prescaler_clr(prescaler_clr),
  .skip_next(skip_next));

// ==== dv/tb.sv ====
// Self-checking bench for the ALU datapath block
`timescale 1ns/1ps
`include "alu_bit_map.svh"
module tb;
  import alu_bit_pkg::*;
  // =========
  // Drive and observe
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, pins_in = 32'h0, prdata, rd, st;
  logic        pready, pslverr, prescaler_clr, skip_next, er;
  int          bad_count = 0, compares = 0, skips = 0, clrs = 0;
  always #50 pclk = ~pclk;
  alu_bit_core DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .prescaler_clr(prescaler_clr),
    .skip_next(skip_next));
  // Count hook pulses as the edges sample them
  always @(posedge pclk) begin
    if (skip_next === 1'b1) skips++;
    if (prescaler_clr === 1'b1) clrs++;
  end
  // =========
  // APB transfer; an idle cycle follows so no strobe is set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp=%h got=%h", nm, e, g);
    end
  endtask
  task automatic rg(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Run one op, then poll busy; writes while busy would be dropped
  task automatic ex(op_t op, logic [7:0] k, logic [6:0] f, logic [2:0] b, logic dst);
    apb(1'b1, `OFS_OPERAND, {11'h0, dst, 1'b0, b, 1'b0, f, k});
    apb(1'b1, `OFS_CTRL, {25'h0, op, 4'h1});
    do apb(1'b0, `OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
    st = rd;
  endtask
  // File byte reaches the accumulator through clear then add
  task automatic rdf(logic [6:0] f, logic [7:0] e);
    ex(OP_AND_LIT, 8'h00, 7'h00, 3'h0, 1'b0);
    ex(OP_ADD_FILE, 8'h00, f, 3'h0, 1'b0);
    rg("file", `OFS_ACC, {24'h0, e});
  endtask
  task automatic print_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict;
  end
  // =========
  // Scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rg("acc", `OFS_ACC, 32'h0);
    ex(OP_AND_LIT, 8'h00, 7'h00, 3'h0, 1'b0);
    rg("flags", `OFS_FLAGS, 32'h4);
    ex(OP_ADD_LIT, 8'h8F, 7'h00, 3'h0, 1'b0);
    ex(OP_ADD_LIT, 8'h71, 7'h00, 3'h0, 1'b0);
    rg("acc", `OFS_ACC, 32'h0);
    rg("flags", `OFS_FLAGS, 32'h7);
    ex(OP_ADD_LIT, 8'h08, 7'h00, 3'h0, 1'b0);
    ex(OP_ADD_LIT, 8'h08, 7'h00, 3'h0, 1'b0);
    rg("flags", `OFS_FLAGS, 32'h2);
    ex(OP_BIT_SET, 8'h00, 7'h20, 3'h7, 1'b0);
    ex(OP_BIT_SET, 8'h00, 7'h20, 3'h0, 1'b0);
    rg("flags", `OFS_FLAGS, 32'h2);
    ex(OP_BIT_CLR, 8'h00, 7'h20, 3'h0, 1'b0);
    rg("flags", `OFS_FLAGS, 32'h2);
    rdf(7'h20, 8'h80);
    ex(OP_ADD_FILE, 8'h00, 7'h20, 3'h0, 1'b1);
    rg("acc", `OFS_ACC, 32'h80);
    rg("flags", `OFS_FLAGS, 32'h5);
    rdf(7'h20, 8'h00);
    ex(OP_ADD_LIT, 8'hF0, 7'h00, 3'h0, 1'b0);
    ex(OP_ADD_LIT, 8'hF0, 7'h00, 3'h0, 1'b0);
    ex(OP_BIT_SET, 8'h00, 7'h21, 3'h4, 1'b0);
    ex(OP_AND_FILE, 8'h00, 7'h21, 3'h0, 1'b1);
    rg("acc", `OFS_ACC, 32'hE0);
    rg("flags", `OFS_FLAGS, 32'h5);
    ex(OP_AND_LIT, 8'h3C, 7'h00, 3'h0, 1'b0);
    rg("acc", `OFS_ACC, 32'h20);
    rg("flags", `OFS_FLAGS, 32'h1);
    // Port bytes come from the pins, not the latch
    pins_in <= 32'h0000A501;
    rdf(7'h06, 8'hA5);
    ex(OP_SKIP_ONE, 8'h00, 7'h05, 3'h0, 1'b0);
    chk("skips", 32'h1, 32'(skips));
    chk("status", 32'h2, st);
    ex(OP_SKIP_ONE, 8'h00, 7'h05, 3'h1, 1'b0);
    chk("skips", 32'h1, 32'(skips));
    chk("status", 32'h0, st);
    rg("flags", `OFS_FLAGS, 32'h0);
    apb(1'b1, `OFS_CFG, 32'h1);
    ex(OP_BIT_SET, 8'h00, `TIMER_ADDR, 3'h0, 1'b0);
    chk("clrs", 32'h1, 32'(clrs));
    chk("status", 32'h4, st);
    ex(OP_ADD_FILE, 8'h00, `TIMER_ADDR, 3'h0, 1'b0);
    chk("clrs", 32'h1, 32'(clrs));
    apb(1'b1, `OFS_CFG, 32'h0);
    ex(OP_BIT_CLR, 8'h00, `TIMER_ADDR, 3'h0, 1'b0);
    chk("clrs", 32'h1, 32'(clrs));
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    print_verdict;
  end
endmodule
